// *** pkg/bsx_pkg.sv ***
// Purpose: shared constants and types of the branch/bit-set/move executer
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data addresses
// Notes:   register offsets are byte addresses on the Avalon-MM slave

package bsx_pkg;

  // ==========================================================
  // widths
  localparam int PC_W = 21;
  localparam int DA_W = 12;

  // ==========================================================
  // register map (byte offsets)
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_WORKING_REGISTER   = 6'h08;
  localparam logic [5:0] OFS_BANK   = 6'h0c;
  localparam logic [5:0] OFS_PC     = 6'h10;
  localparam logic [5:0] OFS_PTR0   = 6'h14;
  localparam logic [5:0] OFS_PTR1   = 6'h18;
  localparam logic [5:0] OFS_PTR2   = 6'h1c;

  // ==========================================================
  // field positions
  localparam int CTRL_RUN_BIT  = 0;
  localparam int STAT_NEG_BIT  = 0;
  localparam int STAT_ZERO_BIT = 1;
  localparam int STAT_ILL_BIT  = 2;
  localparam int STAT_BUSY_BIT = 3;

  // ==========================================================
  // values after reset
  localparam logic [PC_W-1:0] RST_PC   = 21'h000000;
  localparam logic [7:0]      RST_WORKING_REGISTER = 8'h00;
  localparam logic [3:0]      RST_BANK = 4'h0;
  localparam logic            RST_RUN  = 1'b0;

  // ==========================================================
  // opcode prefixes
  localparam logic [4:0] OP_BRANCH = 5'h1a;   // 1101 0
  localparam logic [3:0] OP_BITSET = 4'h8;    // 1000
  localparam logic [9:0] OP_PTRLD  = 10'h3b8; // 1110 1110 00
  localparam logic [7:0] OP_PTRLD2 = 8'hf0;   // 1111 0000
  localparam logic [5:0] OP_MOVE   = 6'h14;   // 0101 00

  // ==========================================================
  // access bank split, program counter step and unused pointer select
  localparam logic [7:0]      ACCESS_SPLIT = 8'h80;
  localparam logic [3:0]      ACCESS_HI_BK = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP      = 21'h000002;
  localparam logic [1:0]      PTR_NONE     = 2'h3;

  // ==========================================================
  // quarters of an instruction cycle
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_HALT  = 4'h1,
    ST_EXEC  = 4'h2,
    ST_NOP   = 4'h4,
    ST_WORD2 = 4'h8
  } bsx_state_t;

endpackage : bsx_pkg

// *** pkg/bsx_flag_if.sv ***
// Purpose: carries an operand to the flag/bit unit and its results back
// Assumes: same clock domain on both ends, purely combinational
// Notes:   src drives operand and bit select, unit answers

`timescale 1ns/1ps

interface bsx_flag_if;
  logic [7:0] operand;
  logic [2:0] bit_sel;
  logic [7:0] set_result;
  logic       neg;
  logic       zero;

  // ==========================================================
  modport src  (output operand, output bit_sel,
                input set_result, input neg, input zero);
  modport unit (input operand, input bit_sel,
                output set_result, output neg, output zero);
endinterface : bsx_flag_if

// *** rtl/bsx_flag_unit.sv ***
// Purpose: bit-set merge and negative/zero flags of one data byte
// Assumes: operand is stable through the quarter that uses it
// Notes:   combinational only, no state

`timescale 1ns/1ps

module bsx_flag_unit
  import bsx_pkg::*;
(
  // operand and results
  bsx_flag_if.unit fl
);

  // ==========================================================
  // bit set: one bit forced high, the rest untouched
  always_comb begin
    fl.set_result = fl.operand | (8'h01 << fl.bit_sel);
  end

  // ==========================================================
  // flags of the moved value
  assign fl.neg  = fl.operand[7];
  assign fl.zero = (fl.operand == 8'h00);

endmodule : bsx_flag_unit

// *** rtl/bsx_exec.sv ***
// Purpose: fetch, decode and execute of branch, bit set, pointer load
//          and move, in four quarters per instruction cycle
// Assumes: program and data memories answer on this clock; data memory
//          read data is valid in the quarter after the address is set
// Notes:   registers are reached over Avalon-MM with one wait state

`timescale 1ns/1ps

// Contract
// - a branch loads the pc with the incremented pc plus twice n.
// - a branch takes two cycles, the second doing nothing at all.
// - bit set forces bit b of register f high and keeps the flags.
// - bank field 0 uses the access bank, 1 the bank select register.
// - bit set is one cycle: decode, read f, process, write f back.
// - pointer load puts a 12-bit literal into pointer 0 to 2, no flags.
// - pointer load is two words and cycles, high nibble then low byte.
// - move copies f to the working register when d is 0, else back to f.
// - move sets the negative and zero flags from the moved value.
// - move reaches any f in the bank chosen by the bank field.
// - move reads f in the second quarter and writes in the fourth.
module bsx_exec
  import bsx_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  // program memory fetch
  output logic [PC_W-1:0]        prog_addr_o,
  input  wire logic [15:0]       prog_data_i,
  input  wire logic              prog_valid_i,
  // data memory bus
  output logic [DA_W-1:0]        dmem_addr_o,
  input  wire logic [7:0]        dmem_rdata_i,
  output logic [7:0]             dmem_wdata_o,
  output logic                   dmem_we_o,
  // avalon-mm register slave
  input  wire logic [5:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o
);

  // ==========================================================
  // state of the whole block
  typedef struct packed {
    bsx_state_t            st;
    logic [1:0]            q;
    logic                  run;
    logic [PC_W-1:0]       pc;
    logic [15:0]           ir;
    logic [7:0]            lit_lo;
    logic [7:0]            working_register;
    logic [3:0]            bank;
    logic                  neg;
    logic                  zero;
    logic                  illegal;
    logic [2:0][3:0]       ptr_hi;
    logic [2:0][7:0]       ptr_lo;
    logic [7:0]            tmp;
    logic [DA_W-1:0]       daddr;
    logic                  dwe;
    logic [7:0]            dwdata;
    logic                  ack;
    logic [31:0]           rdata;
  } bsx_core_t;

  bsx_core_t   s;
  bsx_core_t   next_s;
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic        req;
  logic        bus_wr;
  logic        is_bra;
  logic        is_bsf;
  logic        is_ptr;
  logic        is_mov;
  logic [1:0]  ptr_sel;
  logic [PC_W-1:0] br_offs;

  bsx_flag_if  fl ();

  // ==========================================================
  // reset release: asynchronous assert, two-flop release
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ==========================================================
  // flag and bit unit, fed from the latched operand
  assign fl.operand = s.tmp;
  assign fl.bit_sel = s.ir[11:9];

  bsx_flag_unit u_flag (
    .fl (fl)
  );

  // ==========================================================
  // decode of the latched instruction word
  assign is_bra  = (s.ir[15:11] == OP_BRANCH);
  assign is_bsf  = (s.ir[15:12] == OP_BITSET);
  assign is_ptr  = (s.ir[15:6]  == OP_PTRLD);
  assign is_mov  = (s.ir[15:10] == OP_MOVE);
  assign ptr_sel = s.ir[5:4];

  // signed word offset doubled to a byte offset
  assign br_offs = {{(PC_W-12){s.ir[10]}}, s.ir[10:0], 1'b0};

  // ==========================================================
  // data address of a fetched word: access bank or selected bank
  function automatic logic [DA_W-1:0] data_addr(
    input logic [15:0] word,
    input logic [3:0]  bank
  );
    logic [3:0] bk;
    bk = bank;
    if (!word[8]) begin
      // low half of the access bank sits in bank 0, high half on top
      bk = (word[7:0] < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI_BK;
    end
    data_addr = {bk, word[7:0]};
  endfunction : data_addr

  // ==========================================================
  // read mux of the register slave
  function automatic logic [31:0] reg_read(
    input bsx_core_t  c,
    input logic [5:0] addr
  );
    reg_read = 32'h0000_0000;
    case (addr)
      OFS_CTRL: begin
        reg_read[CTRL_RUN_BIT] = c.run;
      end
      OFS_STATUS: begin
        reg_read[STAT_NEG_BIT]  = c.neg;
        reg_read[STAT_ZERO_BIT] = c.zero;
        reg_read[STAT_ILL_BIT]  = c.illegal;
        reg_read[STAT_BUSY_BIT] = (c.st != ST_HALT);
      end
      OFS_WORKING_REGISTER: begin
        reg_read[7:0] = c.working_register;
      end
      OFS_BANK: begin
        reg_read[3:0] = c.bank;
      end
      OFS_PC: begin
        reg_read[PC_W-1:0] = c.pc;
      end
      OFS_PTR0: begin
        reg_read[11:0] = {c.ptr_hi[0], c.ptr_lo[0]};
      end
      OFS_PTR1: begin
        reg_read[11:0] = {c.ptr_hi[1], c.ptr_lo[1]};
      end
      OFS_PTR2: begin
        reg_read[11:0] = {c.ptr_hi[2], c.ptr_lo[2]};
      end
      default: begin
        reg_read = 32'h0000_0000;
      end
    endcase
  endfunction : reg_read

  // ==========================================================
  // bus handshake: one wait state, the write lands on the ack edge
  assign req               = avs_read_i | avs_write_i;
  assign bus_wr            = avs_write_i & s.ack;
  assign avs_waitrequest_o = req & ~s.ack;

  // ==========================================================
  // next state: bus writes first, so a hardware set wins a clear
  always_comb begin
    next_s     = s;
    next_s.dwe = 1'b0;
    next_s.ack = req & ~s.ack;
    if (req & ~s.ack & avs_read_i) begin
      next_s.rdata = reg_read(s, avs_address_i);
    end

    // software writes
    if (bus_wr) begin
      case (avs_address_i)
        OFS_CTRL: begin
          if (avs_byteenable_i[0]) begin
            next_s.run = avs_writedata_i[CTRL_RUN_BIT];
          end
        end
        OFS_STATUS: begin
          // write one to clear the sticky decode error
          if (avs_byteenable_i[0] && avs_writedata_i[STAT_ILL_BIT]) begin
            next_s.illegal = 1'b0;
          end
        end
        OFS_WORKING_REGISTER: begin
          if (avs_byteenable_i[0]) begin
            next_s.working_register = avs_writedata_i[7:0];
          end
        end
        OFS_BANK: begin
          if (avs_byteenable_i[0]) begin
            next_s.bank = avs_writedata_i[3:0];
          end
        end
        OFS_PC: begin
          // moving the pc under a running core would tear a fetch
          if (s.st == ST_HALT) begin
            if (avs_byteenable_i[0]) begin
              next_s.pc[7:0] = {avs_writedata_i[7:1], 1'b0};
            end
            if (avs_byteenable_i[1]) begin
              next_s.pc[15:8] = avs_writedata_i[15:8];
            end
            if (avs_byteenable_i[2]) begin
              next_s.pc[PC_W-1:16] = avs_writedata_i[PC_W-1:16];
            end
          end
        end
        default: begin
          next_s.run = next_s.run; // unmapped or pointer offset: write ignored
        end
      endcase
    end

    // instruction sequencer
    case (s.st)
      ST_HALT: begin
        if (s.run) begin
          next_s.st = ST_EXEC;
          next_s.q  = Q1;
        end
      end

      ST_EXEC: begin
        case (s.q)
          Q1: begin
            // decode quarter; stall here until the word is offered
            if (!s.run) begin
              next_s.st = ST_HALT;
            end else if (prog_valid_i) begin
              next_s.ir    = prog_data_i;
              next_s.pc    = s.pc + PC_STEP;
              next_s.daddr = data_addr(prog_data_i, s.bank);
              next_s.q     = Q2;
            end
          end
          Q2: begin
            next_s.tmp = dmem_rdata_i;
            next_s.q   = Q3;
          end
          Q3: begin
            // process quarter; the data write strobe covers Q4 only
            if (is_bsf) begin
              next_s.tmp    = fl.set_result;
              next_s.dwdata = fl.set_result;
              next_s.dwe    = 1'b1;
            end else if (is_mov && s.ir[9]) begin
              next_s.dwdata = s.tmp;
              next_s.dwe    = 1'b1;
            end
            next_s.q = Q4;
          end
          Q4: begin
            next_s.q = Q1;
            if (is_bra) begin
              // pc was already stepped past this word at decode
              next_s.pc = s.pc + br_offs;
              next_s.st = ST_NOP;
            end else if (is_ptr) begin
              if (ptr_sel != PTR_NONE) begin
                next_s.ptr_hi[ptr_sel] = s.ir[3:0];
              end else begin
                next_s.illegal = 1'b1;
              end
              next_s.st = ST_WORD2;
            end else if (is_mov) begin
              if (!s.ir[9]) begin
                next_s.working_register = s.tmp;
              end
              next_s.neg  = fl.neg;
              next_s.zero = fl.zero;
            end else if (!is_bsf) begin
              // unknown word: retired as a one-cycle no-op
              next_s.illegal = 1'b1;
            end
          end
          default: begin
            next_s.q = Q1;
          end
        endcase
      end

      ST_NOP: begin
        // second branch cycle: four idle quarters
        next_s.q = s.q + 2'h1;
        if (s.q == Q4) begin
          next_s.st = ST_EXEC;
        end
      end

      ST_WORD2: begin
        case (s.q)
          Q1: begin
            // second word comes from the next program location
            if (prog_valid_i) begin
              next_s.lit_lo = prog_data_i[7:0];
              next_s.pc     = s.pc + PC_STEP;
              if (prog_data_i[15:8] != OP_PTRLD2) begin
                next_s.illegal = 1'b1;
              end
              next_s.q = Q2;
            end
          end
          Q4: begin
            if (ptr_sel != PTR_NONE) begin
              next_s.ptr_lo[ptr_sel] = s.lit_lo;
            end
            next_s.q  = Q1;
            next_s.st = ST_EXEC;
          end
          default: begin
            next_s.q = s.q + 2'h1;
          end
        endcase
      end

      default: begin
        next_s.st = ST_HALT;
        next_s.q  = Q1;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s      <= '0;
      s.st   <= ST_HALT;
      s.q    <= Q1;
      s.run  <= RST_RUN;
      s.pc   <= RST_PC;
      s.working_register <= RST_WORKING_REGISTER;
      s.bank <= RST_BANK;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops except the wait request
  assign prog_addr_o    = s.pc;
  assign dmem_addr_o    = s.daddr;
  assign dmem_wdata_o   = s.dwdata;
  assign dmem_we_o      = s.dwe;
  assign avs_readdata_o = s.rdata;

endmodule : bsx_exec

// *** bench/bsx_exec_assertions.sv ***
// Purpose: port checks of the instruction executer
// Assumes: one clock; a fetch shows one clock late as a pc step of two
// Notes:   bound into bsx_exec below
`timescale 1ns/1ps
module bsx_exec_chk
  import bsx_pkg::*;
(
  // clock and reset
  input wire logic            ref_clk_i,
  input wire logic            reset_n_i,
  // fetch and data bus
  input wire logic [PC_W-1:0] prog_addr_o,
  input wire logic [15:0]     prog_data_i,
  input wire logic            prog_valid_i,
  input wire logic [DA_W-1:0] dmem_addr_o,
  input wire logic [7:0]      dmem_rdata_i,
  input wire logic [7:0]      dmem_wdata_o,
  input wire logic            dmem_we_o
);
  // ==========
  // helper: word, pc and valid of the last clock
  struct packed {
    logic [15:0]     w;
    logic [PC_W-1:0] a;
    logic            v;
  } q;
  logic f;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) q <= '0;
    else q <= {prog_data_i, prog_addr_o, prog_valid_i};
  end
  // a stalled fetch never steps the pc, so it is not mistaken for one
  assign f = q.v && (prog_addr_o == q.a + PC_STEP);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_bra; f && q.w[15:11] == OP_BRANCH; endsequence
  sequence s_set; f && q.w[15:12] == OP_BITSET; endsequence
  sequence s_mov; f && q.w[15:10] == OP_MOVE; endsequence
  property p_tgt;
    logic [PC_W-1:0] t;
    (s_bra, t = q.a + PC_STEP + {{9{q.w[10]}}, q.w[10:0], 1'b0})
      |-> ##3 prog_addr_o == t;
  endproperty
  property p_set;
    logic [7:0] v;
    logic [2:0] b;
    (s_set, v = dmem_rdata_i, b = q.w[11:9])
      |-> ##2 dmem_we_o && dmem_wdata_o == (v | (8'h01 << b));
  endproperty
  property p_mov;
    logic [7:0] v;
    logic       d;
    (s_mov, v = dmem_rdata_i, d = q.w[9])
      |-> ##2 (d ? dmem_we_o && dmem_wdata_o == v : !dmem_we_o);
  endproperty
  // ==========
  // assertions
  AST_BRA_TGT: assert property (p_tgt)
    else $error("branch target wrong");
  AST_BRA_QUIET: assert property (s_bra |-> !dmem_we_o [*7])
    else $error("data write in branch");
  AST_BRA_HOLD: assert property (
    s_bra |-> ##4 $stable(prog_addr_o) [*3])
    else $error("fetch in idle cycle");
  AST_SET: assert property (p_set)
    else $error("bit set write wrong");
  AST_MOV: assert property (p_mov)
    else $error("move write wrong");
  AST_BANK: assert property (
    f && (q.w[15:12] == OP_BITSET || q.w[15:10] == OP_MOVE)
    |-> dmem_addr_o[7:0] == q.w[7:0] && (q.w[8] ||
        dmem_addr_o[11:8] == (q.w[7] ? ACCESS_HI_BK : 4'h0)))
    else $error("data address wrong");
  AST_PTR: assert property (
    f && q.w[15:6] == OP_PTRLD |-> !dmem_we_o [*3]
    ##[1:9] (f && q.w[15:8] == OP_PTRLD2))
    else $error("second word not fetched");
  AST_WE_ONE: assert property (
    $rose(dmem_we_o) |=> !dmem_we_o [*3])
    else $error("write strobe too long");
endmodule : bsx_exec_chk

bind bsx_exec bsx_exec_chk u_chk (.ref_clk_i, .reset_n_i, .prog_addr_o,
  .prog_data_i, .prog_valid_i, .dmem_addr_o, .dmem_rdata_i,
  .dmem_wdata_o, .dmem_we_o);

// *** bench/bsx_mem_model.sv ***
// Purpose: program and data memories at the far side of the executer
// Assumes: word-wide program memory, byte-wide data memory
// Notes:   slow mode offers a fetch word only every other clock
`timescale 1ns/1ps
module bsx_mem_model
  import bsx_pkg::*;
(
  // clock and pacing
  input  wire logic            ref_clk_i,
  input  wire logic            slow_i,
  // fetch side
  input  wire logic [PC_W-1:0] prog_addr_i,
  output logic [15:0]          prog_data_o,
  output logic                 prog_valid_o,
  // data side
  input  wire logic [DA_W-1:0] dmem_addr_i,
  output logic [7:0]           dmem_rdata_o,
  input  wire logic [7:0]      dmem_wdata_i,
  input  wire logic            dmem_we_i,
  // pc seen in the span a branch skips
  output logic                 skip_hit_o
);
  logic [15:0] pm [0:63];
  logic [7:0]  dm [0:4095];
  logic        tog = 1'b0;
  logic        hit = 1'b0;
  // empty words hold an unknown opcode
  initial begin
    for (int i = 0; i < 64; i++) pm[i] = 16'hffff;
    for (int i = 0; i < 4096; i++) dm[i] = 8'h00;
  end
  // stored writes, pacing and the skip watch
  always @(posedge ref_clk_i) begin
    tog <= ~tog;
    if (dmem_we_i) dm[dmem_addr_i] <= dmem_wdata_i;
    if (prog_addr_i inside {[21'h10:21'h3e]}) hit <= 1'b1;
  end
  // a word not on offer shows its inverse, never a stale copy
  assign prog_valid_o = !slow_i || tog;
  assign prog_data_o  = prog_valid_o ? pm[prog_addr_i[6:1]]
                                     : ~pm[prog_addr_i[6:1]];
  assign dmem_rdata_o = dm[dmem_addr_i];
  assign skip_hit_o   = hit;
endmodule : bsx_mem_model

// *** bench/testbench.sv ***
// Purpose: self-checking bench of the instruction executer
// Assumes: core state reached only over the avalon slave
// Notes:   one program runs all four instructions back to back
`timescale 1ns/1ps
module testbench
  import bsx_pkg::*;
;
  // ==========
  // signals
  logic            ref_clk_i = 1'b0;
  logic            reset_n_i = 1'b0;
  logic            slow = 1'b0;
  logic [5:0]      avs_address_i = 6'h00;
  logic            avs_read_i = 1'b0;
  logic            avs_write_i = 1'b0;
  logic [31:0]     avs_writedata_i = 32'h0;
  logic [3:0]      avs_byteenable_i = 4'hf;
  logic [PC_W-1:0] prog_addr_o;
  logic [15:0]     prog_data_i;
  logic            prog_valid_i;
  logic [DA_W-1:0] dmem_addr_o;
  logic [7:0]      dmem_rdata_i;
  logic [7:0]      dmem_wdata_o;
  logic            dmem_we_o;
  logic [31:0]     avs_readdata_o;
  logic            avs_waitrequest_o;
  logic            skip_hit;
  int              fails = 0;
  int              checked = 0;
  // bit sets, moves, pointer load, branch to 0x40
  logic [15:0] prg [0:6] = '{16'h8e10, 16'h8120, 16'h5010, 16'h5321,
                             16'hee23, 16'hf0ab, 16'hd019};

  bsx_exec u_bsx_exec (
    .ref_clk_i, .reset_n_i, .prog_addr_o, .prog_data_i, .prog_valid_i,
    .dmem_addr_o, .dmem_rdata_i, .dmem_wdata_o, .dmem_we_o,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o);
  bsx_mem_model u_bsx_mem_model (
    .ref_clk_i, .slow_i(slow), .prog_addr_i(prog_addr_o),
    .prog_data_o(prog_data_i), .prog_valid_o(prog_valid_i),
    .dmem_addr_i(dmem_addr_o), .dmem_rdata_o(dmem_rdata_i),
    .dmem_wdata_i(dmem_wdata_o), .dmem_we_i(dmem_we_o),
    .skip_hit_o(skip_hit));

  // 40 MHz clock
  always #12.5 ref_clk_i = ~ref_clk_i;

  // ==========
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until waitrequest is sampled low at a rising edge;
  // no cycle count is assumed, only the watchdog ends a stuck wait
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge ref_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rdc

  // ==========
  // scenarios
  task automatic t_reset;
    rdc(OFS_PC, {11'h0, RST_PC});
    rdc(OFS_WORKING_REGISTER, {24'h0, RST_WORKING_REGISTER});
    rdc(OFS_BANK, {28'h0, RST_BANK});
    rdc(OFS_CTRL, 32'h0);
    wr(6'h3c, 32'hffffffff);
    rdc(6'h3c, 32'h0);
  endtask : t_reset
  // program run on a slow fetch, then halted and inspected
  task automatic t_program;
    logic [31:0] q;
    for (int i = 0; i < 7; i++) u_bsx_mem_model.pm[i] = prg[i];
    u_bsx_mem_model.pm[32] = 16'hd7ff;
    u_bsx_mem_model.dm[12'h010] = 8'h0a;
    u_bsx_mem_model.dm[12'h320] = 8'h40;
    slow <= 1'b1;
    wr(OFS_BANK, 32'h3);
    wr(OFS_CTRL, 32'h1);
    repeat (400) begin
      @(posedge ref_clk_i);
      if (prog_addr_o === 21'h42) break;
    end
    slow <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    repeat (20) begin
      bus(1'b0, OFS_STATUS, 32'h0, q);
      if (q[STAT_BUSY_BIT] === 1'b0) break;
    end
    chk({24'h0, u_bsx_mem_model.dm[12'h010]}, 32'h8a);
    chk({24'h0, u_bsx_mem_model.dm[12'h320]}, 32'h41);
    rdc(OFS_WORKING_REGISTER, 32'h8a);
    rdc(OFS_STATUS, 32'h2);
    rdc(OFS_PTR2, 32'h3ab);
    rdc(OFS_PC, 32'h40);
    chk({31'h0, skip_hit}, 32'h0);
  endtask : t_program
  // unknown word sets the sticky error; pc writes are ignored while running
  task automatic t_illegal;
    logic [31:0] q;
    u_bsx_mem_model.pm[41] = 16'hd7ff;
    wr(OFS_PC, 32'h50);
    rdc(OFS_PC, 32'h50);
    wr(OFS_CTRL, 32'h1);
    repeat (30) @(posedge ref_clk_i);
    wr(OFS_PC, 32'h10);
    wr(OFS_CTRL, 32'h0);
    repeat (20) begin
      bus(1'b0, OFS_STATUS, 32'h0, q);
      if (q[STAT_BUSY_BIT] === 1'b0) break;
    end
    chk(q, 32'h6);
    rdc(OFS_PC, 32'h52);
    wr(OFS_STATUS, 32'h4);
    rdc(OFS_STATUS, 32'h2);
  endtask : t_illegal

  task automatic summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  // reset, scenarios, verdict
  initial begin
    repeat (12) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_reset();
    t_program();
    t_illegal();
    summarize();
  end
  // watchdog, far past the run of under two thousand clocks
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule : testbench
